// ---- rtl/odt_pkg.sv ----
// Purpose : Shared constants and types of the octal DDR memory timing controller
// Assumes : One 40 MHz system clock; all bus timing counted in half bus clocks
// Notes   : Field layouts are packed structs; reset values are the slow boot settings
package odt_pkg;

   // System clock and bus clock figures
   localparam int unsigned SYS_CLK_KHZ      = 40000;
   localparam int unsigned CRYSTAL_KHZ      = 24000;
   localparam int unsigned BUS_FAST_KHZ     = 132000;
   // Crystal-to-bus ratio times two (5.5 -> 11) for the high-speed setting
   localparam int unsigned BUS_RATIO_X2     = (2 * BUS_FAST_KHZ) / CRYSTAL_KHZ;

   // Divider: system cycles per half bus clock
   localparam logic [3:0]  DIV_SLOW         = 4'h8;
   localparam logic [3:0]  DIV_FAST         = 4'h1;

   // Boot fetch address of the flash space
   localparam logic [31:0] BOOT_VECTOR      = 32'h3000_0000;

   // Register select codes on the configuration port
   localparam logic [1:0]  SEL_CS0_CONFIG   = 2'h0;
   localparam logic [1:0]  SEL_CS0_TIMING   = 2'h1;
   localparam logic [1:0]  SEL_CS1_CONFIG   = 2'h2;
   localparam logic [1:0]  SEL_CS1_TIMING   = 2'h3;

   // Command and address phase length in bus clocks
   localparam logic [11:0] CMD_CLOCKS       = 12'h003;

   // Memory configuration word: bit 31 enable, bits 8:0 maximum length
   typedef struct packed {
      logic        maxen;
      logic [21:0] rsvd;
      logic [8:0]  maxlen;
   } odt_config_t;

   // Memory timing word
   typedef struct packed {
      logic [3:0] rsvd;
      logic [3:0] ltcy;
      logic [3:0] wcsh;
      logic [3:0] rcsh;
      logic [3:0] wcss;
      logic [3:0] rcss;
      logic [3:0] wcshi;
      logic [3:0] rcshi;
   } odt_timing_t;

   // Slow, conservative reset values
   localparam odt_config_t CONFIG_RESET = '{maxen: 1'b0, rsvd: 22'h0, maxlen: 9'h1FF};
   localparam odt_timing_t TIMING_RESET = '{rsvd: 4'h0, ltcy: 4'hF, wcsh: 4'hF, rcsh: 4'hF,
                                            wcss: 4'hF, rcss: 4'hF, wcshi: 4'hF, rcshi: 4'hF};

   // Transaction sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_CMD   = 3'b010,
      ST_LAT   = 3'b011,
      ST_DATA  = 3'b100,
      ST_HOLD  = 3'b101,
      ST_GAP   = 3'b110
   } odt_state_t;

   // Transaction request
   typedef struct packed {
      logic       cs;
      logic       write;
      logic [8:0] words;
   } odt_req_t;

endpackage

// ---- rtl/odt_clkdiv.sv ----
// Purpose : Half bus clock enable pulse generator
// Assumes : Rate select is a level synchronous to sys_clk
// Notes   : A rate change takes effect on the next sys_clk cycle, even mid-count
`timescale 1ns/1ps
module odt_clkdiv (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // Rate select
   input  wire logic clk_fast,
   // Half bus clock enable
   output logic      half_tick
);

   logic [3:0] cnt_q;
   logic [3:0] limit;

   assign limit = clk_fast ? odt_pkg::DIV_FAST : odt_pkg::DIV_SLOW;

   // Count system cycles between half bus clocks
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q     <= 4'h0;
         half_tick <= 1'b0;
      end else if (cnt_q + 4'h1 >= limit) begin
         cnt_q     <= 4'h0;
         half_tick <= 1'b1;
      end else begin
         cnt_q     <= cnt_q + 4'h1;
         half_tick <= 1'b0;
      end
   end

endmodule

// ---- rtl/odt_ctrl.sv ----
// Purpose : Two chip-select timing and latency controller for an octal DDR memory bus
// Assumes : Chip select 0 holds flash, chip select 1 holds RAM; inputs synchronous
// Notes   : All phases counted in half bus clocks so 1.5-cycle gaps are exact
`timescale 1ns/1ps

// Behaviour
// - Boot fetch starts at flash space base
// - Bus clock fast setting gives sys_clk/2, 20 MHz at 40 MHz
// - Separate config and timing per chip select
// - Maximum-length enable and 9-bit length limit
// - Read/write chip-select high time, 1.5 minimum
// - Read/write chip-select setup, one clock minimum
// - Read/write chip-select hold, one clock minimum
// - Each chip select inserts its programmed latency clocks
module odt_ctrl (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Configuration write port and readback
   input  wire logic              cfg_we,
   input  wire logic [1:0]        cfg_sel,
   input  wire logic [31:0]       cfg_wdata,
   output logic      [31:0]       cfg_rdata,
   // Bus clock rate select
   input  wire logic              clk_fast,
   // Transaction request
   input  wire logic              req_valid,
   input  wire odt_pkg::odt_req_t req,
   output logic                   req_ready,
   // Memory bus pins
   output logic                   mem_bus_clock,
   output logic                   mem_bus_clock_n,
   output logic                   flash_select_n,
   output logic                   ram_select_n,
   // Status
   output logic                   in_latency,
   output logic                   data_beat,
   output logic                   done,
   output logic                   truncated,
   output logic      [31:0]       boot_vector
);

   odt_pkg::odt_config_t cs0_mem_config_q;
   odt_pkg::odt_config_t cs1_mem_config_q;
   odt_pkg::odt_timing_t cs0_mem_timing_q;
   odt_pkg::odt_timing_t cs1_mem_timing_q;
   odt_pkg::odt_state_t  state_q;
   odt_pkg::odt_req_t    cur_q;
   logic [11:0]          cnt_q;
   logic                 clk_q;
   logic                 half_tick;
   logic                 last_half;
   logic                 clk_run;
   logic                 trunc_q;
   logic [9:0]           eff_words;
   odt_pkg::odt_timing_t t_cur;
   odt_pkg::odt_timing_t t_req;

   // Timing word of a chip select
   function automatic odt_pkg::odt_timing_t tim_of(input logic cs,
                                                   input odt_pkg::odt_timing_t t0,
                                                   input odt_pkg::odt_timing_t t1);
      tim_of = cs ? t1 : t0;
   endfunction

   // Config word of a chip select
   function automatic odt_pkg::odt_config_t cfg_of(input logic cs,
                                                   input odt_pkg::odt_config_t c0,
                                                   input odt_pkg::odt_config_t c1);
      cfg_of = cs ? c1 : c0;
   endfunction

   // States in which the addressed chip select is held low
   function automatic logic in_frame(input odt_pkg::odt_state_t s);
      in_frame = (s inside {odt_pkg::ST_SETUP, odt_pkg::ST_CMD, odt_pkg::ST_LAT,
                            odt_pkg::ST_DATA, odt_pkg::ST_HOLD});
   endfunction

   // Half bus clock enable from the rate divider
   odt_clkdiv u_clkdiv (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .clk_fast  (clk_fast),
      .half_tick (half_tick)
   );

   // Configuration registers, one pair per chip select
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cs0_mem_config_q <= odt_pkg::CONFIG_RESET;
         cs1_mem_config_q <= odt_pkg::CONFIG_RESET;
         cs0_mem_timing_q <= odt_pkg::TIMING_RESET;
         cs1_mem_timing_q <= odt_pkg::TIMING_RESET;
      end else if (cfg_we) begin
         unique case (cfg_sel)
            odt_pkg::SEL_CS0_CONFIG: begin
               cs0_mem_config_q       <= cfg_wdata;
               cs0_mem_config_q.rsvd  <= 22'h0;
            end
            odt_pkg::SEL_CS0_TIMING: begin
               cs0_mem_timing_q       <= cfg_wdata;
               cs0_mem_timing_q.rsvd  <= 4'h0;
            end
            odt_pkg::SEL_CS1_CONFIG: begin
               cs1_mem_config_q       <= cfg_wdata;
               cs1_mem_config_q.rsvd  <= 22'h0;
            end
            odt_pkg::SEL_CS1_TIMING: begin
               cs1_mem_timing_q       <= cfg_wdata;
               cs1_mem_timing_q.rsvd  <= 4'h0;
            end
         endcase
      end
   end

   // Readback of the selected register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata   <= 32'h0000_0000;
         boot_vector <= 32'h0000_0000;
      end else begin
         boot_vector <= odt_pkg::BOOT_VECTOR;
         unique case (cfg_sel)
            odt_pkg::SEL_CS0_CONFIG: cfg_rdata <= cs0_mem_config_q;
            odt_pkg::SEL_CS0_TIMING: cfg_rdata <= cs0_mem_timing_q;
            odt_pkg::SEL_CS1_CONFIG: cfg_rdata <= cs1_mem_config_q;
            odt_pkg::SEL_CS1_TIMING: cfg_rdata <= cs1_mem_timing_q;
         endcase
      end
   end

   // Requested words capped by the maximum length when enabled
   always_comb begin
      odt_pkg::odt_config_t c;
      c = cfg_of(req.cs, cs0_mem_config_q, cs1_mem_config_q);
      if (c.maxen && ({1'b0, req.words} > {1'b0, c.maxlen} + 10'h001)) begin
         eff_words = {1'b0, c.maxlen} + 10'h001;
      end else begin
         eff_words = {1'b0, req.words};
      end
   end

   assign req_ready = (state_q == odt_pkg::ST_IDLE);
   assign last_half = half_tick && (cnt_q == 12'h001);
   assign clk_run   = (state_q == odt_pkg::ST_CMD) || (state_q == odt_pkg::ST_LAT) ||
                      (state_q == odt_pkg::ST_DATA);

   // Timing words of the running and of the offered transfer
   assign t_cur = tim_of(cur_q.cs, cs0_mem_timing_q, cs1_mem_timing_q);
   assign t_req = tim_of(req.cs, cs0_mem_timing_q, cs1_mem_timing_q);

   // Transaction sequencer; every count is in half bus clocks
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= odt_pkg::ST_IDLE;
         cnt_q   <= 12'h000;
         cur_q   <= '0;
         trunc_q <= 1'b0;
      end else begin
         unique case (state_q)
            odt_pkg::ST_IDLE: begin
               if (req_valid) begin
                  cur_q   <= req;
                  cur_q.words <= (eff_words == 10'h000) ? 9'h001 : eff_words[8:0];
                  trunc_q <= (eff_words != {1'b0, req.words});
                  state_q <= odt_pkg::ST_SETUP;
                  // Setup of code n lasts n+1 clocks
                  cnt_q   <= {7'h00, (req.write ? t_req.wcss : t_req.rcss), 1'b0} + 12'h002;
               end
            end
            odt_pkg::ST_SETUP: begin
               if (last_half) begin
                  state_q <= odt_pkg::ST_CMD;
                  cnt_q   <= {odt_pkg::CMD_CLOCKS[10:0], 1'b0};
               end else if (half_tick) begin
                  cnt_q   <= cnt_q - 12'h001;
               end
            end
            odt_pkg::ST_CMD: begin
               if (last_half) begin
                  if (t_cur.ltcy == 4'h0) begin
                     state_q <= odt_pkg::ST_DATA;
                     cnt_q   <= {2'b00, cur_q.words, 1'b0};
                  end else begin
                     state_q <= odt_pkg::ST_LAT;
                     cnt_q   <= {7'h00, t_cur.ltcy, 1'b0};
                  end
               end else if (half_tick) begin
                  cnt_q   <= cnt_q - 12'h001;
               end
            end
            odt_pkg::ST_LAT: begin
               if (last_half) begin
                  state_q <= odt_pkg::ST_DATA;
                  cnt_q   <= {2'b00, cur_q.words, 1'b0};
               end else if (half_tick) begin
                  cnt_q   <= cnt_q - 12'h001;
               end
            end
            odt_pkg::ST_DATA: begin
               if (last_half) begin
                  state_q <= odt_pkg::ST_HOLD;
                  // Hold of code n lasts n+1 clocks
                  cnt_q   <= {7'h00, (cur_q.write ? t_cur.wcsh : t_cur.rcsh), 1'b0} + 12'h002;
               end else if (half_tick) begin
                  cnt_q   <= cnt_q - 12'h001;
               end
            end
            odt_pkg::ST_HOLD: begin
               if (last_half) begin
                  state_q <= odt_pkg::ST_GAP;
                  // High time of code n lasts n+1.5 clocks
                  cnt_q   <= {7'h00, (cur_q.write ? t_cur.wcshi : t_cur.rcshi), 1'b0} + 12'h003;
               end else if (half_tick) begin
                  cnt_q   <= cnt_q - 12'h001;
               end
            end
            odt_pkg::ST_GAP: begin
               if (last_half) begin
                  state_q <= odt_pkg::ST_IDLE;
               end else if (half_tick) begin
                  cnt_q   <= cnt_q - 12'h001;
               end
            end
            default: begin
               state_q <= odt_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Bus clock toggles only during command, latency and data; parks low
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clk_q           <= 1'b0;
         mem_bus_clock   <= 1'b0;
         mem_bus_clock_n <= 1'b1;
      end else begin
         if (half_tick) begin
            clk_q <= clk_run ? ~clk_q : 1'b0;
         end
         mem_bus_clock   <= clk_q;
         mem_bus_clock_n <= ~clk_q;
      end
   end

   // Chip selects low from setup through hold, separate per select
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flash_select_n <= 1'b1;
         ram_select_n   <= 1'b1;
      end else begin
         flash_select_n <= !in_frame(state_q) || cur_q.cs;
         ram_select_n   <= !in_frame(state_q) || !cur_q.cs;
      end
   end

   // Status flags and end-of-transaction pulses
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_latency <= 1'b0;
         data_beat  <= 1'b0;
         done       <= 1'b0;
         truncated  <= 1'b0;
      end else begin
         in_latency <= (state_q == odt_pkg::ST_LAT);
         data_beat  <= (state_q == odt_pkg::ST_DATA) && half_tick && clk_q;
         done       <= (state_q == odt_pkg::ST_GAP) && last_half;
         truncated  <= (state_q == odt_pkg::ST_GAP) && last_half && trunc_q;
      end
   end

endmodule

// ---- verif/odt_ctrl_monitor.sv ----
// Purpose: Port-level protocol checks of the timing controller
// Assumes: One sys_clk domain, rstn asynchronous and active low
// Notes:   Attached to every controller instance by the bind below
`timescale 1ns/1ps
module odt_ctrl_monitor (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // Observed outputs
   input wire logic        req_ready,
   input wire logic        mem_bus_clock,
   input wire logic        mem_bus_clock_n,
   input wire logic        flash_select_n,
   input wire logic        ram_select_n,
   input wire logic        in_latency,
   input wire logic        data_beat,
   input wire logic        done,
   input wire logic        truncated,
   input wire logic [31:0] boot_vector
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic busy;

   // Any chip select active
   assign busy = !flash_select_n || !ram_select_n;

   boot_fetch_a: assert property ($past(rstn) |-> boot_vector == odt_pkg::BOOT_VECTOR)
      else $error("boot vector wrong");
   clock_pair_a: assert property (mem_bus_clock_n == !mem_bus_clock)
      else $error("bus clock pair not complementary");
   one_select_a: assert property (!(!flash_select_n && !ram_select_n))
      else $error("both selects low");
   busy_ready_a: assert property (busy |-> !req_ready)
      else $error("ready while selected");
   trunc_done_a: assert property (truncated |-> done)
      else $error("truncated without done");
   idle_clock_a: assert property (!busy |-> !mem_bus_clock)
      else $error("bus clock high outside select");
   phase_inside_a: assert property ((data_beat || in_latency) |-> busy)
      else $error("latency or beat outside select");
   done_pulse_a: assert property (done |-> !busy ##1 !done)
      else $error("done not a single idle pulse");
   gap_bound_a: assert property (($rose(flash_select_n) || $rose(ram_select_n)) |-> ##[1:300] done)
      else $error("no done after select high");

   // Main scenarios reached
   cover property (truncated);
   cover property ($rose(in_latency));
   cover property ($fell(ram_select_n));
endmodule

bind odt_ctrl odt_ctrl_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn), .req_ready(req_ready),
   .mem_bus_clock(mem_bus_clock), .mem_bus_clock_n(mem_bus_clock_n), .flash_select_n(flash_select_n),
   .ram_select_n(ram_select_n), .in_latency(in_latency), .data_beat(data_beat), .done(done),
   .truncated(truncated), .boot_vector(boot_vector));

// ---- verif/odt_mem_model.sv ----
// Purpose: Flash and RAM seen from the bus: latency codes and clock edges
// Assumes: Bus pins sampled on sys_clk, which runs faster than the bus clock
// Notes:   Reserved latency codes report -1
`timescale 1ns/1ps
module odt_mem_model (
   // Clock and bus pins
   input wire logic       sys_clk,
   input wire logic       mem_bus_clock,
   input wire logic       flash_select_n,
   input wire logic       ram_select_n,
   // Latency fields held in the memories
   input wire logic [7:0] flash_volatile_config,
   input wire logic [7:0] ram_config0,
   // Latency each memory expects and bus clock edges of its last frame
   output int             flash_ltcy,
   output int             ram_ltcy,
   output int             flash_edges,
   output int             ram_edges
);
   logic clk_q;
   logic fsel_q;
   logic rsel_q;

   // Flash codes 0 to 11 give 5 to 16 clocks
   always_comb begin
      flash_ltcy = (flash_volatile_config[7:4] <= 4'hB) ? 5 + flash_volatile_config[7:4] : -1;
   end

   // RAM code map, middle codes reserved
   always_comb begin
      case (ram_config0[7:4])
         4'h0: ram_ltcy = 5;
         4'h1: ram_ltcy = 6;
         4'hE: ram_ltcy = 3;
         4'hF: ram_ltcy = 4;
         default: ram_ltcy = -1;
      endcase
   end

   // Count rising bus clocks while each device is selected
   always @(posedge sys_clk) begin
      clk_q <= mem_bus_clock;
      fsel_q <= flash_select_n;
      rsel_q <= ram_select_n;
      if (fsel_q && !flash_select_n) flash_edges <= 0;
      else if (!flash_select_n && mem_bus_clock && !clk_q) flash_edges <= flash_edges + 1;
      if (rsel_q && !ram_select_n) ram_edges <= 0;
      else if (!ram_select_n && mem_bus_clock && !clk_q) ram_edges <= ram_edges + 1;
   end
endmodule

// ---- verif/test_octal_ddr_mem_timing_config.sv ----
// Purpose: Self-checking bench of the two chip-select timing controller
// Assumes: 40 MHz sys_clk, inputs driven on the falling edge
// Notes:   Phase lengths measured per transfer and compared with a model
`timescale 1ns/1ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_octal_ddr_mem_timing_config;
   logic                 sys_clk, rstn, cfg_we, clk_fast, req_valid, req_ready;
   logic                 mclk, mclk_n, fsel_n, rsel_n, in_lat, beat, done, trunc;
   logic [1:0]           cfg_sel;
   logic [31:0]          cfg_wdata, cfg_rdata, boot_vector;
   logic [7:0]           fcode, rcode;
   odt_pkg::odt_req_t    req;
   odt_pkg::odt_timing_t tm[2];
   odt_pkg::odt_config_t cf[2];
   int                   flat, rlat, fedge, redge, errors, total_checks, seed, sel_cnt, lat_cnt, beat_cnt, gap_cnt;
   int                   exp_q[$];

   odt_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .clk_fast(clk_fast), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .mem_bus_clock(mclk), .mem_bus_clock_n(mclk_n), .flash_select_n(fsel_n), .ram_select_n(rsel_n),
      .in_latency(in_lat), .data_beat(beat), .done(done), .truncated(trunc), .boot_vector(boot_vector));
   odt_mem_model MEM (.sys_clk(sys_clk), .mem_bus_clock(mclk), .flash_select_n(fsel_n), .ram_select_n(rsel_n),
      .flash_volatile_config(fcode), .ram_config0(rcode), .flash_ltcy(flat), .ram_ltcy(rlat),
      .flash_edges(fedge), .ram_edges(redge));

   // 25 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Activity of the running transfer, cleared when a request is taken
   always @(posedge sys_clk) begin
      if (req_valid && req_ready) begin
         sel_cnt = 0;
         lat_cnt = 0;
         beat_cnt = 0;
         gap_cnt = 0;
      end else begin
         sel_cnt += !(fsel_n && rsel_n);
         lat_cnt += in_lat;
         beat_cnt += beat;
         gap_cnt += fsel_n && rsel_n && !req_ready;
      end
   end

   task automatic finish_test();
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic rst();
      rstn = 1'b0;
      tm = '{odt_pkg::TIMING_RESET, odt_pkg::TIMING_RESET};
      cf = '{odt_pkg::CONFIG_RESET, odt_pkg::CONFIG_RESET};
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
   endtask

   task automatic wr(input logic [1:0] s, input logic [31:0] d);
      @(negedge sys_clk);
      cfg_we = 1'b1;
      cfg_sel = s;
      cfg_wdata = d;
      @(negedge sys_clk);
      cfg_we = 1'b0;
   endtask

   task automatic rd(input logic [1:0] s, input logic [31:0] e);
      cfg_sel = s;
      @(negedge sys_clk);
      `CHK(cfg_rdata, e, "register readback")
   endtask

   // Program one chip select, then read every register back
   task automatic prog(input logic c, input logic [31:0] cw, input logic [31:0] tw);
      cf[c] = cw;
      tm[c] = tw;
      wr({c, 1'b0}, cw);
      wr({c, 1'b1}, tw);
      for (int i = 0; i < 4; i++) begin
         rd(i[1:0], i[0] ? {4'h0, tm[i[1]][27:0]} : (cf[i[1]] & 32'h8000_01FF));
      end
   endtask

   // One transfer; expectations built from the shadow registers
   task automatic run(input logic c, input logic w, input int words, input logic f);
      int css, csh, cshi, lt, wc, n, k, h;
      logic tr;
      css = w ? tm[c].wcss : tm[c].rcss;
      csh = w ? tm[c].wcsh : tm[c].rcsh;
      cshi = w ? tm[c].wcshi : tm[c].rcshi;
      lt = tm[c].ltcy;
      wc = (words == 0) ? 1 : words;
      tr = cf[c].maxen && wc > cf[c].maxlen + 1;
      if (tr) wc = cf[c].maxlen + 1;
      h = f ? 1 : 8;
      exp_q.push_back(2 * (css + 1) + 6 + 2 * lt + 2 * wc + 2 * (csh + 1));
      @(negedge sys_clk);
      clk_fast = f;
      req_valid = 1'b1;
      req = '{cs: c, write: w, words: words[8:0]};
      @(negedge sys_clk);
      req_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 3000) begin
         @(negedge sys_clk);
         k++;
      end
      `CHK(k < 3000, 1'b1, "transfer never completed")
      `CHK(trunc, tr, "truncation flag")
      `CHK(beat_cnt, wc, "data beat count")
      `CHK(lat_cnt, 2 * h * lt, "latency length")
      `CHK(c ? redge : fedge, 3 + lt + wc, "bus clocks in frame")
      n = exp_q.pop_front();
      if (f) begin
         `CHK(sel_cnt, n, "select low time")
         `CHK(gap_cnt >= 2 * cshi + 2 && gap_cnt <= 2 * cshi + 5, 1'b1, "select high gap")
      end else begin
         `CHK(sel_cnt >= 8 * n - 8 && sel_cnt <= 8 * n + 1, 1'b1, "slow select low time")
      end
   endtask

   // Watchdog
   initial begin
      #1500000;
      errors++;
      finish_test();
   end

   // Main sequence
   initial begin
      {cfg_we, clk_fast, req_valid, cfg_sel, cfg_wdata, req} = '0;
      fcode = 8'hB0;
      rcode = 8'h10;
      seed = 32'h4258D14B;
      rst();
      for (int i = 0; i < 4; i++) rd(i[1:0], i[0] ? 32'h0FFF_FFFF : 32'h0000_01FF);
      `CHK(boot_vector, odt_pkg::BOOT_VECTOR, "boot address")
      run(1'b0, 1'b0, 4, 1'b0);
      // Loader fast flash setup, then RAM setup with a length cap
      fcode = 8'h80;
      rcode = 8'h00;
      // Let the memory model settle on the new codes before they are copied
      @(negedge sys_clk);
      `CHK(flat, 13, "flash latency code")
      `CHK(rlat, 5, "RAM latency code")
      prog(1'b0, 32'h0, {4'h0, flat[3:0], 24'h0});
      prog(1'b1, 32'h8000_0002, {4'h0, rlat[3:0], 24'h0});
      run(1'b0, 1'b0, 8, 1'b1);
      run(1'b0, 1'b1, 2, 1'b1);
      run(1'b1, 1'b0, 7, 1'b1);
      run(1'b1, 1'b1, 0, 1'b1);
      for (int i = 0; i < 12; i++) begin
         prog(i[0], $random(seed) & 32'hFFFF_FE0F, $random(seed));
         run(i[0], $random(seed), $random(seed) & 31, ($random(seed) & 3) != 0);
      end
      // Reset in mid transfer returns the slow defaults
      @(negedge sys_clk);
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      repeat (5) @(negedge sys_clk);
      rstn = 1'b0;
      #1;
      `CHK(fsel_n && rsel_n, 1'b1, "selects high in reset")
      rst();
      for (int i = 0; i < 4; i++) rd(i[1:0], i[0] ? 32'h0FFF_FFFF : 32'h0000_01FF);
      finish_test();
   end
endmodule
